// file: rtl/dlt_pkg.sv
// Shared constants, types and register map for the dual engine level trigger
package dlt_pkg;

    // Threshold and sample codes are unsigned 8-bit fractions of full scale
    typedef logic [7:0] dlt_code_t;

    // Level code that stands for zero volts on the trigger source
    localparam dlt_code_t DLT_LEVEL_ZERO = 8'h80;

    // Trigger source of one engine
    typedef enum logic [1:0] {
        DLT_SRC_CH_A   = 2'b00,  // Converter channel A
        DLT_SRC_CH_B   = 2'b01,  // Converter channel B
        DLT_SRC_EXT    = 2'b10,  // External trigger input samples
        DLT_SRC_OFF    = 2'b11   // Engine disabled
    } dlt_src_e;

    // Edge direction that counts as an event
    typedef enum logic {
        DLT_SLOPE_RISE = 1'b0,   // Samples rise above level
        DLT_SLOPE_FALL = 1'b1    // Samples fall below level
    } dlt_slope_e;

    // How engine events make the board trigger
    typedef enum logic [1:0] {
        DLT_OP_FIRST   = 2'b00,  // use_first_engine_only
        DLT_OP_SECOND  = 2'b01,  // use_second_engine_only
        DLT_OP_EITHER  = 2'b10   // use_either_engine
    } dlt_op_e;

    // Settings of one engine
    typedef struct packed {
        dlt_src_e   src;         // Source selection
        dlt_slope_e slope;       // Slope selection
        dlt_code_t  level;       // threshold_code
    } dlt_cfg_s;

    // Sample stream from the converters, one code per source
    typedef struct packed {
        dlt_code_t ch_a;         // Channel A sample
        dlt_code_t ch_b;         // Channel B sample
        dlt_code_t ext;          // External input sample
        logic      valid;        // New sample set this cycle
    } dlt_samples_s;

    // State of one engine
    typedef struct packed {
        dlt_code_t prev;         // Previous sample of the source
        logic      have_prev;    // Previous sample is meaningful
        logic      event_hit;    // One-cycle crossing event
    } dlt_eng_state_s;

    // State of the top block
    typedef struct packed {
        dlt_op_e   op;           // Board trigger operation
        dlt_cfg_s  cfg_first;    // first_trigger_engine settings
        dlt_cfg_s  cfg_second;   // second_trigger_engine settings
        logic      clr_first;    // History clear, first engine
        logic      clr_second;   // History clear, second engine
        logic [31:0] rdata;      // Read data for access phase
        logic      ready;        // Access phase answer
        logic      slverr;       // Unmapped address answer
        logic      trig;         // Board trigger pulse
        logic [15:0] count;      // Board triggers seen
    } dlt_top_state_s;

    // Register byte offsets
    localparam logic [7:0] DLT_OFF_OP     = 8'h00;  // Operation
    localparam logic [7:0] DLT_OFF_CFG    = 8'h04;  // Engine configuration write
    localparam logic [7:0] DLT_OFF_FIRST  = 8'h08;  // First engine readback
    localparam logic [7:0] DLT_OFF_SECOND = 8'h0c;  // Second engine readback
    localparam logic [7:0] DLT_OFF_STATUS = 8'h10;  // Count and history flags

    // Field positions
    localparam int DLT_OP_LSB    = 0;   // Operation field
    localparam int DLT_ENG_BIT   = 0;   // Engine selector, 1 = second
    localparam int DLT_SRC_LSB   = 4;   // Source field
    localparam int DLT_SLOPE_BIT = 8;   // Slope bit
    localparam int DLT_LVL_LSB   = 16;  // Level field
    localparam int DLT_CNT_LSB   = 0;   // Trigger count
    localparam int DLT_ARM1_BIT  = 16;  // First engine has history
    localparam int DLT_ARM2_BIT  = 17;  // Second engine has history

    // Byte lanes that carry each field
    localparam int DLT_LANE_LOW  = 0;   // Engine, source, operation
    localparam int DLT_LANE_SLP  = 1;   // Slope
    localparam int DLT_LANE_LVL  = 2;   // Level

    // Reset values
    localparam dlt_op_e  DLT_OP_RESET  = DLT_OP_FIRST;
    localparam dlt_cfg_s DLT_CFG_RESET = '{src: DLT_SRC_OFF, slope: DLT_SLOPE_RISE,
                                           level: DLT_LEVEL_ZERO};
    localparam logic [15:0] DLT_CNT_ONE = 16'h0001;

endpackage

// file: rtl/dlt_source_mux.sv
// Trigger source selector feeding one engine comparator
`timescale 1ns/1ps
`default_nettype none
module dlt_source_mux
    import dlt_pkg::*;
(
    input  wire dlt_samples_s samples,    // All sample streams
    input  wire dlt_src_e     src,        // Selected source
    output logic [7:0]        code,       // Selected sample code
    output logic              code_valid  // Selected sample is new
);

    // Pick the stream; a disabled engine never sees a valid sample
    always_comb begin
        code       = samples.ch_a;
        code_valid = samples.valid;
        unique case (src)
            DLT_SRC_CH_A: code = samples.ch_a;
            DLT_SRC_CH_B: code = samples.ch_b;
            DLT_SRC_EXT:  code = samples.ext;
            DLT_SRC_OFF:  code_valid = 1'b0;
        endcase
    end

endmodule
`default_nettype wire

// file: rtl/dlt_engine.sv
// One level trigger engine: crossing detector on an 8-bit code
`timescale 1ns/1ps
`default_nettype none
module dlt_engine
    import dlt_pkg::*;
(
    input  wire logic         pclk,        // Sample clock
    input  wire logic         presetn,     // Async reset, active low
    input  wire dlt_cfg_s     cfg,         // Slope and level
    input  wire logic         clear,       // Drop sample history
    input  wire logic [7:0]   code,        // Selected sample
    input  wire logic         code_valid,  // Sample is new
    output logic              event_hit,   // Crossing pulse
    output logic              armed        // History present
);

    dlt_eng_state_s st_ff;                 // Registered state
    dlt_eng_state_s nxt_st;                // Next state
    logic           rise_x;                // Upward crossing
    logic           fall_x;                // Downward crossing

    // Unsigned compare of previous and current sample against level
    assign rise_x = (st_ff.prev <= cfg.level) && (code > cfg.level);
    assign fall_x = (st_ff.prev >= cfg.level) && (code < cfg.level);

    // Next state: history update and event pulse
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.event_hit = 1'b0;
        if (clear) begin
            // New settings: forget the old sample to avoid a false edge
            nxt_st.have_prev = 1'b0;
        end else if (code_valid) begin
            nxt_st.prev      = code;
            nxt_st.have_prev = 1'b1;
            if (st_ff.have_prev) begin
                nxt_st.event_hit = (cfg.slope == DLT_SLOPE_RISE) ? rise_x : fall_x;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign event_hit = st_ff.event_hit;
    assign armed     = st_ff.have_prev;

    // Checks on the crossing detector
    sequence s_step;
        !clear && code_valid && st_ff.have_prev;
    endsequence

    AST_ENG_RISE: assert property (@(posedge pclk) disable iff (!presetn)
        s_step and (cfg.slope == DLT_SLOPE_RISE) && rise_x |=> event_hit)
        else $error("Rising crossing missed");
    AST_ENG_FALL: assert property (@(posedge pclk) disable iff (!presetn)
        s_step and (cfg.slope == DLT_SLOPE_FALL) && fall_x |=> event_hit)
        else $error("Falling crossing missed");
    AST_ENG_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
        event_hit && $stable(cfg) |-> !nxt_st.event_hit)
        else $error("Engine retriggered without a new crossing");

endmodule
`default_nettype wire

// file: rtl/dlt_trigger_top.sv
// Dual engine level trigger with APB register access
//
// What this block does
// - Two engines, each configured and detecting independently
// - Engine events combine only by OR
// - Configuration write names one engine and touches it
// - Source selection picks the comparator input per engine
// - Rising slope: event when samples cross above level
// - Falling slope: event when samples cross below level
// - Threshold is an unsigned 8-bit code
// - Code 0 negative, 128 zero, 255 positive full scale
// - Operation picks first only, second only, or either
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dlt_trigger_top
    import dlt_pkg::*;
(
    input  wire logic         pclk,          // Clock, 20 MHz
    input  wire logic         presetn,       // Async reset, active low
    input  wire logic [7:0]   paddr,         // APB byte address
    input  wire logic         psel,          // APB select
    input  wire logic         penable,       // APB access phase
    input  wire logic         pwrite,        // APB write
    input  wire logic [31:0]  pwdata,        // APB write data
    input  wire logic [3:0]   pstrb,         // APB byte strobes
    output logic [31:0]       prdata,        // APB read data
    output logic              pready,        // APB ready
    output logic              pslverr,       // APB error, unmapped address
    input  wire dlt_samples_s samples,       // Converter sample streams
    output logic              first_event,   // First engine event pulse
    output logic              second_event,  // Second engine event pulse
    output logic              board_trigger  // Board trigger pulse
);

    // Timing at a glance: every bus transfer is answered in the
    // cycle after its setup, with no wait states.
    // An engine pulse reaches board_trigger one cycle later through
    // a flop; the trigger count follows one cycle after that.
    // Writing an engine clears its history, so a sample pair that
    // spans old and new settings never raises an event.
    // The error flag may linger one cycle past its access phase;
    // a master reads it only together with pready.

    dlt_top_state_s st_ff;                   // Registered state
    dlt_top_state_s nxt_st;                  // Next state
    logic [7:0]     code1;                   // First engine sample
    logic [7:0]     code2;                   // Second engine sample
    logic           val1;                    // First engine sample valid
    logic           val2;                    // Second engine sample valid
    logic           ev1;                     // First engine event
    logic           ev2;                     // Second engine event
    logic           arm1;                    // First engine history
    logic           arm2;                    // Second engine history
    logic           setup;                   // APB setup phase
    logic           wr_take;                 // Write completes this edge
    logic           mapped;                  // Address decodes
    logic           cfg_wr;                  // Engine configuration write
    logic           to_second;               // Selector names second engine

    // Readback word of one engine's settings
    function automatic logic [31:0] cfg_word(input dlt_cfg_s c);
        logic [31:0] w;
        w                         = '0;
        w[DLT_SRC_LSB +: 2]       = c.src;
        w[DLT_SLOPE_BIT]          = c.slope;
        w[DLT_LVL_LSB +: 8]       = c.level;
        return w;
    endfunction

    // Apply the strobed fields of a configuration write
    function automatic dlt_cfg_s cfg_merge(input dlt_cfg_s c,
                                           input logic [31:0] d,
                                           input logic [3:0] be);
        dlt_cfg_s r;
        r = c;
        // Engine lane carries the source field
        if (be[DLT_LANE_LOW]) begin
            r.src = dlt_src_e'(d[DLT_SRC_LSB +: 2]);
        end
        // Slope lane
        if (be[DLT_LANE_SLP]) begin
            r.slope = dlt_slope_e'(d[DLT_SLOPE_BIT]);
        end
        // Level lane
        if (be[DLT_LANE_LVL]) begin
            r.level = d[DLT_LVL_LSB +: 8];
        end
        return r;
    endfunction

    // Source selection, one per engine
    dlt_source_mux u_mux_first (
        .samples    (samples),
        .src        (st_ff.cfg_first.src),
        .code       (code1),
        .code_valid (val1)
    );

    dlt_source_mux u_mux_second (
        .samples    (samples),
        .src        (st_ff.cfg_second.src),
        .code       (code2),
        .code_valid (val2)
    );

    // Two independent engines, each with its own settings
    dlt_engine u_eng_first (
        .pclk       (pclk),
        .presetn    (presetn),
        .cfg        (st_ff.cfg_first),
        .clear      (st_ff.clr_first),
        .code       (code1),
        .code_valid (val1),
        .event_hit  (ev1),
        .armed      (arm1)
    );

    dlt_engine u_eng_second (
        .pclk       (pclk),
        .presetn    (presetn),
        .cfg        (st_ff.cfg_second),
        .clear      (st_ff.clr_second),
        .code       (code2),
        .code_valid (val2),
        .event_hit  (ev2),
        .armed      (arm2)
    );

    // Bus phase decode
    assign setup     = psel && !penable;
    assign wr_take   = psel && penable && st_ff.ready && pwrite && !st_ff.slverr;
    assign mapped    = (paddr == DLT_OFF_OP) || (paddr == DLT_OFF_CFG) ||
                       (paddr == DLT_OFF_FIRST) || (paddr == DLT_OFF_SECOND) ||
                       (paddr == DLT_OFF_STATUS);
    // Selector lane must be strobed, or the write is not for any engine
    assign cfg_wr    = wr_take && (paddr == DLT_OFF_CFG) && pstrb[DLT_LANE_LOW];
    assign to_second = pwdata[DLT_ENG_BIT];

    // Next state: bus slave, settings and board trigger
    always_comb begin
        nxt_st            = st_ff;
        nxt_st.clr_first  = 1'b0;
        nxt_st.clr_second = 1'b0;
        // Answer in the access phase right after every setup
        nxt_st.ready      = setup;
        if (setup) begin
            // Decode now so the answer leaves a flop
            nxt_st.slverr = !mapped;
            nxt_st.rdata  = '0;
            // Reads capture the settings at setup
            if (!pwrite) begin
                unique case (paddr)
                    DLT_OFF_OP: begin
                        nxt_st.rdata[DLT_OP_LSB +: 2] = st_ff.op;
                    end
                    DLT_OFF_FIRST: begin
                        nxt_st.rdata = cfg_word(st_ff.cfg_first);
                    end
                    DLT_OFF_SECOND: begin
                        nxt_st.rdata = cfg_word(st_ff.cfg_second);
                    end
                    DLT_OFF_STATUS: begin
                        nxt_st.rdata[DLT_CNT_LSB +: 16] = st_ff.count;
                        nxt_st.rdata[DLT_ARM1_BIT]      = arm1;
                        nxt_st.rdata[DLT_ARM2_BIT]      = arm2;
                    end
                    default: begin
                        // Write-only command word and holes read as zero
                        nxt_st.rdata = '0;
                    end
                endcase
            end
        end else if (!(psel && penable)) begin
            // Bus idle: drop the error flag
            nxt_st.slverr = 1'b0;
        end
        // Operation write; the unused code leaves the setting alone
        if (wr_take && (paddr == DLT_OFF_OP) && pstrb[DLT_LANE_LOW] &&
            (pwdata[DLT_OP_LSB +: 2] != 2'b11)) begin
            nxt_st.op = dlt_op_e'(pwdata[DLT_OP_LSB +: 2]);
        end
        // Configuration goes to the named engine only
        if (cfg_wr) begin
            if (to_second) begin
                nxt_st.cfg_second = cfg_merge(st_ff.cfg_second, pwdata, pstrb);
                nxt_st.clr_second = 1'b1;
            end else begin
                nxt_st.cfg_first  = cfg_merge(st_ff.cfg_first, pwdata, pstrb);
                nxt_st.clr_first  = 1'b1;
            end
        end
        // Board trigger: selected engine, or OR of both, nothing else
        unique case (st_ff.op)
            DLT_OP_FIRST:  nxt_st.trig = ev1;
            DLT_OP_SECOND: nxt_st.trig = ev2;
            DLT_OP_EITHER: nxt_st.trig = ev1 || ev2;
            default:       nxt_st.trig = 1'b0;
        endcase
        // Count board triggers, wrapping at the top
        if (st_ff.trig) begin
            nxt_st.count = st_ff.count + DLT_CNT_ONE;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Idle: first only, both engines off
            st_ff            <= '0;
            st_ff.op         <= DLT_OP_RESET;
            st_ff.cfg_first  <= DLT_CFG_RESET;
            st_ff.cfg_second <= DLT_CFG_RESET;
        end else begin
            // Whole state advances as one word
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flip-flops
    assign prdata        = st_ff.rdata;
    assign pready        = st_ff.ready;
    assign pslverr       = st_ff.slverr;
    assign first_event   = ev1;
    assign second_event  = ev2;
    assign board_trigger = st_ff.trig;

    // Checks on bus, configuration and trigger combination
    // Write for the first engine
    sequence s_cfg_first;
        cfg_wr && !to_second;
    endsequence

    // Write for the second engine
    sequence s_cfg_second;
        cfg_wr && to_second;
    endsequence

    // Write that strobes the level lane
    sequence s_level_write;
        cfg_wr && pstrb[DLT_LANE_LVL];
    endsequence

    // One-cycle answer after every setup
    AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready)
        else $error("APB answer not one cycle after setup");

    // First engine write leaves second alone
    AST_CFG_ONLY_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
        s_cfg_first |=> $stable(st_ff.cfg_second))
        else $error("Write for first engine changed second engine");

    // Second engine write leaves first alone
    AST_CFG_ONLY_SECOND: assert property (@(posedge pclk) disable iff (!presetn)
        s_cfg_second |=> $stable(st_ff.cfg_first))
        else $error("Write for second engine changed first engine");

    // Level lands in the first engine
    AST_CFG_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        s_level_write and s_cfg_first |=>
        st_ff.cfg_first.level == $past(pwdata[DLT_LVL_LSB +: 8]))
        else $error("Level code not taken by first engine");

    // Level lands in the second engine
    AST_CFG_LEVEL_SECOND: assert property (@(posedge pclk) disable iff (!presetn)
        s_level_write and s_cfg_second |=>
        st_ff.cfg_second.level == $past(pwdata[DLT_LVL_LSB +: 8]))
        else $error("Level code not taken by second engine");

    // Write without the engine lane is dropped
    AST_CFG_NO_LANE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_take && (paddr == DLT_OFF_CFG) && !pstrb[DLT_LANE_LOW] |=>
        $stable(st_ff.cfg_first) && $stable(st_ff.cfg_second))
        else $error("Write without engine lane changed an engine");

    // Unused operation code keeps the setting
    AST_OP_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        wr_take && (paddr == DLT_OFF_OP) && (pwdata[DLT_OP_LSB +: 2] == 2'b11) |=>
        $stable(st_ff.op))
        else $error("Unused operation code changed the setting");

    // First only follows the first engine
    AST_OP_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
        (st_ff.op == DLT_OP_FIRST) |=> board_trigger == $past(ev1))
        else $error("First-only operation mismatch");

    // Second only follows the second engine
    AST_OP_SECOND: assert property (@(posedge pclk) disable iff (!presetn)
        (st_ff.op == DLT_OP_SECOND) |=> board_trigger == $past(ev2))
        else $error("Second-only operation mismatch");

    // Either engine: a plain OR
    AST_OP_OR: assert property (@(posedge pclk) disable iff (!presetn)
        (st_ff.op == DLT_OP_EITHER) |=> board_trigger == $past(ev1 || ev2))
        else $error("Either-engine operation is not an OR");

    // Second engine write keeps first history
    AST_INDEPENDENT: assert property (@(posedge pclk) disable iff (!presetn)
        s_cfg_second ##1 st_ff.clr_second |-> !st_ff.clr_first)
        else $error("Second engine write disturbed first engine history");

endmodule
`default_nettype wire

// file: bench/dlt_adc_model.sv
// Converter sample stream model that feeds the trigger block
`timescale 1ns/1ps
`default_nettype none
module dlt_adc_model
    import dlt_pkg::*;
(
    input  wire logic         pclk,       // Sample clock
    input  wire logic         presetn,    // Async reset, active low
    input  wire logic         req_valid,  // Present a new sample set
    input  wire dlt_code_t    req_a,      // Channel A code to present
    input  wire dlt_code_t    req_b,      // Channel B code to present
    input  wire dlt_code_t    req_e,      // External code to present
    output dlt_samples_s      samples     // Stream into the block
);
    // Register one sample set a cycle; idle codes toggle so stale data is never reused
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samples <= '0;
        end else if (req_valid) begin
            samples <= '{ch_a: req_a, ch_b: req_b, ext: req_e, valid: 1'b1};
        end else begin
            samples <= '{ch_a: ~samples.ch_a, ch_b: ~samples.ch_b,
                         ext: ~samples.ext, valid: 1'b0};
        end
    end
endmodule
`default_nettype wire

// file: bench/dual_engine_level_trigger_test.sv
// Self-checking bench for the dual engine level trigger
`timescale 1ns/1ps
`default_nettype none
module dual_engine_level_trigger_test;
    import dlt_pkg::*;
    logic         pclk;        // 20 MHz clock
    logic         presetn;     // Reset, active low
    logic [7:0]   paddr;       // APB address
    logic         psel;        // APB select
    logic         penable;     // APB enable
    logic         pwrite;      // APB direction
    logic [31:0]  pwdata;      // APB write data
    logic [3:0]   pstrb;       // APB strobes
    logic [31:0]  prdata;      // APB read data
    logic         pready;      // APB ready
    logic         pslverr;     // APB error
    dlt_samples_s samples;     // Sample stream
    logic         first_event, second_event, board_trigger;  // Trigger pulses
    logic         req_v;       // Model request
    dlt_code_t    req_a, req_b, req_e;  // Model codes
    int           error_cnt, cmp_count, cycles;  // Report and timeout counters
    int           n1, n2, nb;  // Pulse counts seen
    logic [31:0]  rd;          // Read result
    logic         er;          // Read error flag
    dlt_code_t    lvl2;        // Second engine level
    dlt_op_e      ops [3];     // Operations under test
    int           binc [3];    // Board pulses per operation pass
    int           b0;          // Board count before a pass

    dlt_trigger_top u_dlt_trigger_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .samples(samples),
        .first_event(first_event), .second_event(second_event),
        .board_trigger(board_trigger));
    dlt_adc_model u_dlt_adc_model (.pclk(pclk), .presetn(presetn), .req_valid(req_v),
        .req_a(req_a), .req_b(req_b), .req_e(req_e), .samples(samples));

    // Clock generator
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Pulse counters and hang guard
    always @(posedge pclk) begin
        cycles++;
        if (first_event === 1'b1) n1++;
        if (second_event === 1'b1) n2++;
        if (board_trigger === 1'b1) nb++;
        if (cycles == 5000) begin
            error_cnt++;
            $display("[FAIL] %0t run did not finish", $time);
            close_out();
        end
    end

    // Verdict
    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp, input string m);
        cmp_count++;
        if (got != exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %0d exp %0d", $time, m, got, exp);
        end
    endtask

    // One APB transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Configuration word; with eng 0 it is also the readback layout
    function automatic logic [31:0] cfgw(input logic eng, input logic [1:0] src,
                                         input logic slp, input dlt_code_t lv);
        return {8'h00, lv, 7'h00, slp, 2'b00, src, 3'b000, eng};
    endfunction

    task automatic smp(input dlt_code_t a, input dlt_code_t b, input dlt_code_t e);
        @(posedge pclk);
        req_v <= 1'b1;
        req_a <= a;
        req_b <= b;
        req_e <= e;
    endtask

    task automatic idle();
        @(posedge pclk);
        req_v <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask

    initial begin
        {paddr, psel, penable, pwrite, pwdata, req_v, req_a, req_b, req_e} = '0;
        pstrb = 4'hf;
        {error_cnt, cmp_count, cycles, n1, n2, nb} = '0;
        ops = '{DLT_OP_FIRST, DLT_OP_SECOND, DLT_OP_EITHER};
        binc = '{1, 1, 2};
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, DLT_OFF_OP, '0);
        chk_word(rd, 32'h0000_0000, "op reset");
        apb(1'b0, DLT_OFF_FIRST, '0);
        chk_word(rd, cfgw(1'b0, 2'd3, 1'b0, 8'h80), "first reset");
        apb(1'b0, 8'h14, '0);
        chk_word({er, rd[30:0]}, 32'h8000_0000, "unmapped read");
        // Engines: first on ch A rising at 0 V, second on ch B falling at -50 %
        lvl2 = 8'd128 - 8'd64;  // 128 + 127 * -0.5 truncates to 64
        apb(1'b1, DLT_OFF_CFG, cfgw(1'b0, 2'd0, 1'b0, 8'h80));
        apb(1'b1, DLT_OFF_CFG, cfgw(1'b1, 2'd1, 1'b1, lvl2));
        apb(1'b0, DLT_OFF_FIRST, '0);
        chk_word(rd, cfgw(1'b0, 2'd0, 1'b0, 8'h80), "first cfg");
        apb(1'b0, DLT_OFF_SECOND, '0);
        chk_word(rd, cfgw(1'b0, 2'd1, 1'b1, lvl2), "second cfg");
        // Each operation: one rise on A, one fall on B, levels held beyond
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, DLT_OFF_OP, {30'h0, ops[i]});
            apb(1'b0, DLT_OFF_OP, '0);
            chk_word(rd, {30'h0, ops[i]}, "op readback");
            {n1, n2} = '0;
            b0 = nb;
            smp(8'h70, 8'h50, 8'h00);
            smp(8'h90, 8'h50, 8'h00);
            smp(8'ha0, 8'h50, 8'h00);
            smp(8'ha0, 8'h30, 8'h00);
            smp(8'ha0, 8'h20, 8'h00);
            smp(8'h70, 8'h50, 8'h00);
            idle();
            chk_cnt(n1, 1, "first events");
            chk_cnt(n2, 1, "second events");
            chk_cnt(nb - b0, binc[i], "board pulses");
        end
        apb(1'b1, DLT_OFF_OP, 32'h0000_0003);
        apb(1'b0, DLT_OFF_OP, '0);
        chk_word(rd, {30'h0, DLT_OP_EITHER}, "op code 3 ignored");
        apb(1'b0, DLT_OFF_STATUS, '0);
        chk_word(rd, 32'h0003_0004, "board count and history");
        // First engine on external input at level 254, one below top code, second engine off
        apb(1'b1, DLT_OFF_CFG, cfgw(1'b0, 2'd2, 1'b0, 8'hfe));
        apb(1'b1, DLT_OFF_CFG, cfgw(1'b1, 2'd3, 1'b1, lvl2));
        {n1, n2} = '0;
        b0 = nb;
        smp(8'h70, 8'h50, 8'hfe);
        smp(8'h90, 8'h30, 8'hff);
        smp(8'h70, 8'h50, 8'hff);
        idle();
        chk_cnt(n1, 1, "external event");
        chk_cnt(n2, 0, "disabled engine");
        chk_cnt(nb - b0, 1, "board external");
        // Configuration write without the engine lane must be dropped
        pstrb <= 4'h4;
        apb(1'b1, DLT_OFF_CFG, cfgw(1'b0, 2'd0, 1'b1, 8'h10));
        apb(1'b0, DLT_OFF_FIRST, '0);
        chk_word(rd, cfgw(1'b0, 2'd2, 1'b0, 8'hfe), "first ext cfg");
        close_out();
    end
endmodule
`default_nettype wire
